// ### logic/rpi_device.sv
// Contract
// - Five frequency, seven amplitude ranges, three-bit codes
// - Frequency codes zero..four select 100Hz..1MHz
// - Separate overrange bit per quantity
// - Four/six BCD digits, effective only in remote
// - Standby bit forces 1mV, output disconnected
// - Phase lock bit zero enables lock
// - Remote bit one gives source control
// - Remote bit zero: panel, unless panel remote
// - Sense bit one external, zero internal
// - One 54-bit word of 15 bytes
// - Word loaded parallel or byte-serial
// - Source sends bytes on shared nibble lines
// - Source: data, then address, then strobe
// - Four address lines, four data lines
// - Only addressed portion captures on strobe
// - Device acts only after transfer command
// - Logic one active regardless of polarity option
// - Amplitude codes 1..7 decades, zero gives 1mV
// - Address drives one-of-sixteen decoder
// - Unused data lines ignored for narrow bytes
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module rpi_device
    import rpi_pkg::*;
#(
    parameter bit ACTIVE_LOW = 1'b0
) (
    input  wire logic           ref_clk,
    input  wire logic           rst,
    rpi_link_if.device          link,
    input  wire logic           panel_remote_position,
    output logic [4:0]          freq_range_sel_ff,
    output logic [6:0]          amp_range_sel_ff,
    output logic                freq_overrange_ff,
    output logic                amp_overrange_ff,
    output logic [15:0]         freq_digits_ff,
    output logic [23:0]         amp_digits_ff,
    output logic                output_connect_ff,
    output logic                phase_lock_en_ff,
    output logic                remote_mode_ff,
    output logic                panel_enable_ff,
    output logic                sense_external_ff,
    output logic                transfer_done_ff,
    output logic [14:0]         loaded_mask_ff,
    output logic [53:0]         active_word_ff
);

    ////////////////////////////////////////////////////////////////////////////
    // Input conditioning
    logic [3:0]  data_in;
    logic [3:0]  addr_in;
    logic        strobe_in;
    logic        pload_in;
    logic [53:0] word_in;
    logic        strobe_q_ff;
    logic        pload_q_ff;
    logic        stb_rise;
    logic        pload_rise;
    logic [15:0] addr_sel;
    logic        xfer;
    logic [53:0] in_word;
    logic [53:0] hold_ff;

    // The polarity option only flips levels; logic one stays the active state
    assign data_in   = link.prog_data ^ {4{ACTIVE_LOW}};
    assign addr_in   = link.byte_addr ^ {4{ACTIVE_LOW}};
    assign strobe_in = link.byte_strobe ^ ACTIVE_LOW;
    assign pload_in  = link.par_load ^ ACTIVE_LOW;
    assign word_in   = link.par_word ^ {54{ACTIVE_LOW}};

    // Edges, so a long strobe writes a portion only once
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strobe_q_ff <= 1'b0;
            pload_q_ff  <= 1'b0;
        end else begin
            strobe_q_ff <= strobe_in;
            pload_q_ff  <= pload_in;
        end
    end

    assign stb_rise   = strobe_in & ~strobe_q_ff;
    assign pload_rise = pload_in & ~pload_q_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and input register
    assign addr_sel = 16'h0001 << addr_in;
    assign xfer     = stb_rise & addr_sel[RPI_XFER_ADDR];

    for (genvar i = 0; i < RPI_BYTES; i++) begin : g_portion
        rpi_portion #(
            .W (RPI_BYTE_WID[i])
        ) u_portion (
            .ref_clk (ref_clk),
            .rst     (rst),
            .wr_en   (stb_rise & addr_sel[i]),
            .wr_data (data_in[RPI_BYTE_WID[i]-1:0]),
            .ld_en   (pload_rise),
            .ld_data (word_in[RPI_BYTE_POS[i] +: RPI_BYTE_WID[i]]),
            .q_ff    (in_word[RPI_BYTE_POS[i] +: RPI_BYTE_WID[i]])
        );
    end

    // Two spare positions of the word carry nothing
    assign in_word[RPI_WORD_W-1:RPI_USED_W] = '0;

    ////////////////////////////////////////////////////////////////////////////
    // Record of portions written since the last transfer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            loaded_mask_ff <= '0;
        end else if (xfer || pload_rise) begin
            loaded_mask_ff <= pload_rise ? '1 : '0;
        end else if (stb_rise) begin
            loaded_mask_ff <= loaded_mask_ff | addr_sel[14:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Holding register: a half-loaded word never reaches the settings
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_ff <= RPI_WORD_RST;
        end else if (xfer) begin
            hold_ff <= in_word;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            transfer_done_ff <= 1'b0;
            active_word_ff   <= RPI_WORD_RST;
        end else begin
            transfer_done_ff <= xfer;
            active_word_ff   <= hold_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the held word
    logic [2:0] frq_code;
    logic [2:0] amp_code;
    logic [3:0] ctl;
    logic       remote;
    logic       standby;
    logic [4:0] nxt_freq_sel;
    logic [6:0] nxt_amp_sel;

    assign frq_code = hold_ff[RPI_FRQ_RNG +: 3];
    assign amp_code = hold_ff[RPI_AMP_RNG +: 3];
    assign ctl      = hold_ff[RPI_CTL +: 4];
    assign standby  = ctl[RPI_CTL_STBY];
    // Panel switch in its remote position overrides a zero remote bit
    assign remote   = ctl[RPI_CTL_REM] | panel_remote_position;

    always_comb begin
        nxt_freq_sel = '0;
        // Codes five to seven name no range and select none
        if (frq_code <= RPI_FRQ_1MHZ) begin
            nxt_freq_sel[frq_code] = 1'b1;
        end
    end

    always_comb begin
        nxt_amp_sel = '0;
        if (standby || amp_code < RPI_AMP_1MV) begin
            nxt_amp_sel[0] = 1'b1;
        end else begin
            nxt_amp_sel[amp_code - RPI_AMP_1MV] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ranges and overrange
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            freq_range_sel_ff <= 5'h01;
            amp_range_sel_ff  <= 7'h01;
            freq_overrange_ff <= 1'b0;
            amp_overrange_ff  <= 1'b0;
        end else begin
            freq_range_sel_ff <= nxt_freq_sel;
            amp_range_sel_ff  <= nxt_amp_sel;
            freq_overrange_ff <= hold_ff[RPI_FRQ_OVR];
            amp_overrange_ff  <= hold_ff[RPI_AMP_OVR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Digits: the front panel owns them outside remote mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            freq_digits_ff <= '0;
            amp_digits_ff  <= '0;
        end else if (remote) begin
            freq_digits_ff <= hold_ff[RPI_FRQ_DIG +: 16];
            amp_digits_ff  <= hold_ff[RPI_AMP_DIG +: 24];
        end else begin
            freq_digits_ff <= '0;
            amp_digits_ff  <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control functions
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            output_connect_ff <= 1'b1;
            phase_lock_en_ff  <= 1'b1;
            remote_mode_ff    <= 1'b0;
            panel_enable_ff   <= 1'b1;
            sense_external_ff <= 1'b0;
        end else begin
            output_connect_ff <= ~standby;
            phase_lock_en_ff  <= ~ctl[RPI_CTL_PLOCK];
            remote_mode_ff    <= remote;
            panel_enable_ff   <= ~remote;
            sense_external_ff <= ctl[RPI_CTL_SENSE];
        end
    end

endmodule : rpi_device
`default_nettype wire

// ### logic/rpi_host.sv
`timescale 1ns/1ns
`default_nettype none
module rpi_host
    import rpi_pkg::*;
#(
    parameter bit ACTIVE_LOW = 1'b0
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    rpi_link_if.source       link
);

    typedef enum logic [2:0] {H_IDLE, H_DATA, H_ADDR, H_STB, H_GAP, H_PLOAD} rpi_state_type;

    rpi_state_type state_ff;
    logic [53:0]   word_ff;
    logic [3:0]    idx_ff;
    logic [3:0]    data_ff;
    logic [3:0]    addr_ff;
    logic          strobe_ff;
    logic          pload_ff;
    logic [53:0]   pword_ff;
    logic [31:0]   prdata_ff;
    logic          busy;
    logic          wr_acc;
    logic          mapped;
    logic [53:0]   shifted;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data latched in the setup cycle
    assign busy   = (state_ff != H_IDLE);
    assign mapped = (paddr == RPI_REG_WORD_LO) || (paddr == RPI_REG_WORD_HI) ||
                    (paddr == RPI_REG_CMD) || (paddr == RPI_REG_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_ff;
    assign wr_acc  = psel & penable & pwrite & mapped;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata_ff <= '0;
        end else if (psel && !penable) begin
            if (paddr == RPI_REG_WORD_LO) begin
                prdata_ff <= word_ff[31:0];
            end else if (paddr == RPI_REG_WORD_HI) begin
                prdata_ff <= {10'h000, word_ff[53:32]};
            end else if (paddr == RPI_REG_STATUS) begin
                prdata_ff <= {31'h00000000, busy};
            end else begin
                prdata_ff <= '0;
            end
        end
    end

    // The word stays frozen while it is being sent
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_ff <= RPI_WORD_RST;
        end else if (wr_acc && !busy) begin
            if (paddr == RPI_REG_WORD_LO) begin
                word_ff[31:0] <= pwdata;
            end else if (paddr == RPI_REG_WORD_HI) begin
                word_ff[53:32] <= pwdata[RPI_HI_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link sequencer
    assign shifted = word_ff >> RPI_BYTE_POS[(idx_ff < 4'(RPI_BYTES)) ? idx_ff : 4'h0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff  <= H_IDLE;
            idx_ff    <= '0;
            data_ff   <= '0;
            addr_ff   <= '0;
            strobe_ff <= 1'b0;
            pload_ff  <= 1'b0;
            pword_ff  <= RPI_WORD_RST;
        end else begin
            case (state_ff)
                H_IDLE: begin
                    if (wr_acc && paddr == RPI_REG_CMD && pwdata[RPI_CMD_PARALL]) begin
                        pword_ff <= word_ff;
                        pload_ff <= 1'b1;
                        state_ff <= H_PLOAD;
                    end else if (wr_acc && paddr == RPI_REG_CMD && pwdata[RPI_CMD_SERIAL]) begin
                        idx_ff   <= '0;
                        state_ff <= H_DATA;
                    end
                end
                H_PLOAD: begin
                    pload_ff <= 1'b0;
                    idx_ff   <= RPI_XFER_ADDR;
                    state_ff <= H_DATA;
                end
                H_DATA: begin
                    // Neighbour bits may sit on lines a narrow byte does not use
                    data_ff  <= (idx_ff == RPI_XFER_ADDR) ? 4'h0 : shifted[3:0];
                    state_ff <= H_ADDR;
                end
                H_ADDR: begin
                    addr_ff  <= idx_ff;
                    state_ff <= H_STB;
                end
                H_STB: begin
                    strobe_ff <= 1'b1;
                    state_ff  <= H_GAP;
                end
                H_GAP: begin
                    strobe_ff <= 1'b0;
                    if (idx_ff == RPI_XFER_ADDR) begin
                        state_ff <= H_IDLE;
                    end else if (idx_ff == 4'(RPI_BYTES - 1)) begin
                        idx_ff   <= RPI_XFER_ADDR;
                        state_ff <= H_DATA;
                    end else begin
                        idx_ff   <= idx_ff + 4'h1;
                        state_ff <= H_DATA;
                    end
                end
                default: begin
                    state_ff <= H_IDLE;
                end
            endcase
        end
    end

    assign link.prog_data   = data_ff ^ {4{ACTIVE_LOW}};
    assign link.byte_addr   = addr_ff ^ {4{ACTIVE_LOW}};
    assign link.byte_strobe = strobe_ff ^ ACTIVE_LOW;
    assign link.par_load    = pload_ff ^ ACTIVE_LOW;
    assign link.par_word    = pword_ff ^ {54{ACTIVE_LOW}};

endmodule : rpi_host
`default_nettype wire

// ### logic/rpi_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rpi_link_if;
    logic [3:0]  prog_data;
    logic [3:0]  byte_addr;
    logic        byte_strobe;
    logic [53:0] par_word;
    logic        par_load;
    modport source (output prog_data, output byte_addr, output byte_strobe, output par_word, output par_load);
    modport device (input prog_data, input byte_addr, input byte_strobe, input par_word, input par_load);
endinterface : rpi_link_if
`default_nettype wire

// ### logic/rpi_pkg.sv
`default_nettype none
package rpi_pkg;
    // Program word and serial byte geometry
    localparam int                RPI_WORD_W    = 54;
    localparam int                RPI_BYTES     = 15;
    localparam int                RPI_DATA_W    = 4;
    localparam int                RPI_ADDR_W    = 4;
    localparam logic [3:0]        RPI_XFER_ADDR = 4'hF;
    localparam logic [53:0]       RPI_WORD_RST  = 54'h0;
    // Bit position and width of each byte address inside the word
    localparam int RPI_BYTE_POS [RPI_BYTES] = '{0, 1, 5, 9, 13, 17, 21, 25, 28, 29, 33, 37, 41, 45, 48};
    localparam int RPI_BYTE_WID [RPI_BYTES] = '{1, 4, 4, 4, 4, 4, 4, 3, 1, 4, 4, 4, 4, 3, 4};
    localparam int                RPI_USED_W    = 52;
    // Field positions
    localparam int                RPI_AMP_OVR   = 0;
    localparam int                RPI_AMP_DIG   = 1;
    localparam int                RPI_AMP_RNG   = 25;
    localparam int                RPI_FRQ_OVR   = 28;
    localparam int                RPI_FRQ_DIG   = 29;
    localparam int                RPI_FRQ_RNG   = 45;
    localparam int                RPI_CTL       = 48;
    localparam int                RPI_CTL_SENSE = 0;
    localparam int                RPI_CTL_REM   = 1;
    localparam int                RPI_CTL_PLOCK = 2;
    localparam int                RPI_CTL_STBY  = 3;
    // Range coding
    localparam int                RPI_FRQ_RANGES = 5;
    localparam int                RPI_AMP_RANGES = 7;
    localparam logic [2:0]        RPI_FRQ_1MHZ   = 3'h4;
    localparam logic [2:0]        RPI_AMP_1MV    = 3'h1;
    // Controller registers on APB
    localparam logic [7:0]        RPI_REG_WORD_LO = 8'h00;
    localparam logic [7:0]        RPI_REG_WORD_HI = 8'h04;
    localparam logic [7:0]        RPI_REG_CMD     = 8'h08;
    localparam logic [7:0]        RPI_REG_STATUS  = 8'h0C;
    localparam int                RPI_CMD_SERIAL  = 0;
    localparam int                RPI_CMD_PARALL  = 1;
    localparam int                RPI_HI_W        = 22;
endpackage : rpi_pkg
`default_nettype wire

// ### logic/rpi_portion.sv
`timescale 1ns/1ns
`default_nettype none
module rpi_portion #(
    parameter int W = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         ld_en,
    input  wire logic [W-1:0] ld_data,
    output logic      [W-1:0] q_ff
);
    // Serial byte write has priority; a source never uses both paths at once
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q_ff <= '0;
        end else if (wr_en) begin
            q_ff <= wr_data;
        end else if (ld_en) begin
            q_ff <= ld_data;
        end
    end
endmodule : rpi_portion
`default_nettype wire

// ### verif/rpi_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rpi_link_properties
    import rpi_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [3:0]  prog_data,
    input wire logic [3:0]  byte_addr,
    input wire logic        byte_strobe,
    input wire logic [53:0] par_word,
    input wire logic        par_load
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // A long strobe would let one byte land twice after an address change
    a_strobe_pulse: assert property ($rose(byte_strobe) |=> !byte_strobe)
        else $error("strobe high for more than one cycle");
    a_addr_setup: assert property ($rose(byte_strobe) |-> $stable(byte_addr))
        else $error("address moved at strobe");
    a_data_setup: assert property ($rose(byte_strobe) |-> $past(prog_data, 2) == prog_data)
        else $error("data not set before address");
    a_hold_after: assert property ($fell(byte_strobe) |-> $stable(byte_addr) && $stable(prog_data))
        else $error("data or address dropped with strobe");
    a_load_pulse: assert property (par_load |=> !par_load ##1 $stable(par_word))
        else $error("parallel load not a held single pulse");
    a_no_overlap: assert property (!(par_load && byte_strobe))
        else $error("parallel and serial load together");
    a_xfer_last: assert property ($rose(byte_strobe) && byte_addr == RPI_XFER_ADDR |->
        $past(par_load, 4) || ($past(byte_strobe, 4) && $past(byte_addr, 4) == 4'hE))
        else $error("transfer before word complete");
    a_serial_order: assert property ($rose(byte_strobe) && byte_addr inside {[4'h1:4'hE]} |->
        $past(byte_strobe, 4) && $past(byte_addr, 4) == byte_addr - 4'h1)
        else $error("serial bytes out of order");
endmodule : rpi_link_properties
`default_nettype wire

// ### verif/tb_remote_program_input_register.sv
`timescale 1ns/1ns
`default_nettype none
module tb_remote_program_input_register
    import rpi_pkg::*;
;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, panel, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  f_rng;
    logic [6:0]  a_rng;
    logic        f_ovr, a_ovr, out_con, plock, remote, pnl_en, sense, done;
    logic [15:0] f_dig;
    logic [23:0] a_dig;
    logic [14:0] mask;
    logic [53:0] act, cur;
    int          miscompares, n_checks;
    ////////////////////////////////////////////////////////////////////////////////
    rpi_link_if link ();
    rpi_host i_rpi_host (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    rpi_device i_rpi_device (.ref_clk(ref_clk), .rst(rst), .link(link), .panel_remote_position(panel),
        .freq_range_sel_ff(f_rng), .amp_range_sel_ff(a_rng), .freq_overrange_ff(f_ovr),
        .amp_overrange_ff(a_ovr), .freq_digits_ff(f_dig), .amp_digits_ff(a_dig),
        .output_connect_ff(out_con), .phase_lock_en_ff(plock), .remote_mode_ff(remote),
        .panel_enable_ff(pnl_en), .sense_external_ff(sense), .transfer_done_ff(done),
        .loaded_mask_ff(mask), .active_word_ff(act));
    rpi_link_properties i_rpi_link_properties (.ref_clk(ref_clk), .rst(rst), .prog_data(link.prog_data),
        .byte_addr(link.byte_addr), .byte_strobe(link.byte_strobe), .par_word(link.par_word),
        .par_load(link.par_load));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    // Zero-wait slave, but the wait loop stays so a stalled slave shows up as a timeout
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        @(posedge ref_clk);
        while (pready !== 1'h1) @(posedge ref_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask : apb

    task automatic send(input logic [53:0] w, input logic par);
        logic [31:0] q;
        logic        e;
        logic        rm;
        int          n;
        apb(1'h1, RPI_REG_WORD_LO, w[31:0], q, e);
        apb(1'h1, RPI_REG_WORD_HI, {10'h000, w[53:32]}, q, e);
        apb(1'h0, RPI_REG_WORD_LO, 32'h0, q, e);
        chk("word_lo", 64'({e, q}), 64'({1'h0, w[31:0]}));
        apb(1'h0, RPI_REG_WORD_HI, 32'h0, q, e);
        chk("word_hi", 64'({e, q}), 64'({1'h0, 10'h000, w[53:32]}));
        apb(1'h1, RPI_REG_CMD, {30'h0, par, !par}, q, e);
        n = 0;
        // Polling starts off the edge so the mask is never read as it changes
        do begin
            @(negedge ref_clk);
            n++;
        end while (mask !== 15'h7FFF && n < 200);
        chk("mask", 64'(mask), 64'h7FFF);
        // Whole word is in, transfer not yet seen: outputs must still hold the old word
        chk("held_word", 64'(act), 64'(cur));
        n = 0;
        while (done !== 1'h1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        chk("done", 64'(done), 64'h1);
        chk("done_word", 64'(act), 64'(cur));
        @(negedge ref_clk);
        chk("done_pulse", 64'(done), 64'h0);
        @(posedge ref_clk);
        do apb(1'h0, RPI_REG_STATUS, 32'h0, q, e); while (q[0] !== 1'h0);
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        cur = {2'h0, w[51:0]};
        rm = w[49] | panel;
        chk("word", 64'(act), 64'(cur));
        chk("f_rng", 64'(f_rng), 64'(w[47:45] < 3'h5 ? 5'h01 << w[47:45] : 5'h00));
        chk("a_rng", 64'(a_rng), 64'(w[27:25] == 3'h0 || w[51] ? 7'h01 : 7'h01 << (w[27:25] - 3'h1)));
        chk("ovr", 64'({f_ovr, a_ovr}), 64'({w[28], w[0]}));
        chk("f_dig", 64'(f_dig), 64'(rm ? w[44:29] : 16'h0));
        chk("a_dig", 64'(a_dig), 64'(rm ? w[24:1] : 24'h0));
        chk("ctl", 64'({out_con, plock, remote, pnl_en, sense}), 64'({!w[51], !w[50], rm, !rm, w[48]}));
        chk("mode", 64'({remote, plock, sense}), 64'({rm, !w[50], w[48]}));
        // Next bus request must start right after a rising edge
        @(posedge ref_clk);
    endtask : send

    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        panel = 1'h0;
        cur = '0;
        miscompares = 0;
        n_checks = 0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("rst_word", 64'(act), 64'h0);
        chk("rst_mask", 64'(mask), 64'h0);
        chk("rst_out", 64'({f_rng, a_rng, out_con, plock, remote, pnl_en, sense}), 64'({5'h01, 7'h01, 5'h1A}));
        @(posedge ref_clk);
        apb(1'h0, 8'h10, 32'h0, rd, err);
        chk("unmapped", 64'({err, rd}), 64'({1'h1, 32'h0}));
        // Codes 0..7 for both ranges, each control bit both ways, every remote bit and panel combination, odd passes parallel
        for (int i = 0; i < 8; i++) begin
            panel <= i[2];
            send({2'h0, 4'(i * 5), 3'(i), 16'h9081 + 16'(i), i[0], 3'(7 - i), 24'h765432 - 24'(i), i[1]},
                 i[0]);
        end
        end_of_test();
    end
endmodule : tb_remote_program_input_register
`default_nettype wire
